// ### verilog/csd_pkg.sv
// Constants shared by the source-detection and input-limit logic.
// Assumes a single 200 MHz clock and analog comparators that deliver coded results.
package csd_pkg;

  localparam longint CLK_HZ = 200000000;

  // Configuration-channel debounce times in milliseconds.
  localparam longint CC_ATTACH_MS = 100;
  localparam longint CC_LEVEL_MS  = 10;
  localparam int unsigned CC_ATTACH_CYCLES = int'((CC_ATTACH_MS * CLK_HZ + 999) / 1000);
  localparam int unsigned CC_LEVEL_CYCLES  = int'((CC_LEVEL_MS * CLK_HZ + 999) / 1000);

  // Advertised level seen on one configuration-channel wire.
  localparam logic [1:0] CC_OPEN    = 2'h0;
  localparam logic [1:0] CC_DEFAULT = 2'h1;
  localparam logic [1:0] CC_1A5     = 2'h2;
  localparam logic [1:0] CC_3A0     = 2'h3;

  // Result codes of the D+/D- signature detector.
  localparam logic [3:0] DP_SDP     = 4'h0;
  localparam logic [3:0] DP_CDP     = 4'h1;
  localparam logic [3:0] DP_DCP     = 4'h2;
  localparam logic [3:0] DP_PA_500  = 4'h3;
  localparam logic [3:0] DP_PA_1A   = 4'h4;
  localparam logic [3:0] DP_PA_2A   = 4'h5;
  localparam logic [3:0] DP_PA_2A4  = 4'h6;
  localparam logic [3:0] DP_PB_2A   = 4'h7;
  localparam logic [3:0] DP_UNKNOWN = 4'h8;
  localparam logic [3:0] DP_DCD_TO  = 4'h9;
  localparam logic [3:0] DP_OPEN    = 4'ha;

  // Input current limits in mA.
  localparam logic [11:0] LIM_500  = 12'h1f4;
  localparam logic [11:0] LIM_1000 = 12'h3e8;
  localparam logic [11:0] LIM_1500 = 12'h5dc;
  localparam logic [11:0] LIM_2000 = 12'h7d0;
  localparam logic [11:0] LIM_2400 = 12'h960;
  localparam logic [11:0] LIM_3000 = 12'hbb8;

  // Fast-charge and top-off steps in mA, index 0 is the smallest resistor.
  localparam int FC_STEPS = 15;
  localparam logic [11:0] FAST_MA [FC_STEPS] = '{
    12'h1f4, 12'h258, 12'h320, 12'h3e8, 12'h4b0, 12'h578, 12'h5dc, 12'h708,
    12'h7d0, 12'h898, 12'h960, 12'h9c4, 12'haf0, 12'hbb8, 12'hc4e};
  localparam logic [7:0] TOPOFF_MA [FC_STEPS] = '{
    8'h32, 8'h32, 8'h32, 8'h32, 8'h32, 8'h4b, 8'h4b, 8'h4b,
    8'h64, 8'h64, 8'h7d, 8'h7d, 8'h7d, 8'h96, 8'h96};
  localparam logic [11:0] FAST_MIN = 12'h1f4;
  localparam logic [11:0] FAST_MAX = 12'hc4e;
  localparam logic [7:0]  TOP_MIN  = 8'h32;
  localparam logic [7:0]  TOP_MAX  = 8'h96;

  typedef enum logic [3:0] {
    ST_UNATTACHED  = 4'h1,
    ST_ATTACH_WAIT = 4'h2,
    ST_ATTACHED    = 4'h4,
    ST_SOURCE      = 4'h8
  } csd_state_t;

endpackage : csd_pkg

// ### verilog/csd_sync.sv
// Two-flop synchroniser bank for pin inputs.
// Assumes each bit is a slow level; multi-bit codes must be qualified by the user.
`timescale 1ns/1ps
module csd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge clk) begin
        if (!nrst) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= d[i];
          sync_reg <= meta_reg;
        end
      end
      assign q[i] = sync_reg;
    end
  endgenerate

endmodule : csd_sync

// ### verilog/csd_fast_table.sv
// Maps the fast-charge resistor code to fast-charge and top-off currents.
// Assumes the code comes from a synchronised resistor classifier, 0 to 14.
`timescale 1ns/1ps
module csd_fast_table (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  code,
  output logic      [11:0] fast_ma,
  output logic      [7:0]  topoff_ma
);

  // An out-of-range code picks the lowest step, the safe choice for a bad resistor.
  logic        code_ok;
  logic [3:0]  idx;
  assign code_ok = (code < 4'(csd_pkg::FC_STEPS));
  assign idx     = code_ok ? code : 4'h0;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fast_ma   <= csd_pkg::FAST_MIN;
      topoff_ma <= csd_pkg::TOP_MIN;
    end else begin
      fast_ma   <= csd_pkg::FAST_MA[idx];
      topoff_ma <= csd_pkg::TOPOFF_MA[idx];
    end
  end

endmodule : csd_fast_table

// ### verilog/csd_detect.sv
// Source detection, role control and automatic input current limit.
// Assumes analog comparators and the D+/D- detector deliver codes on pins.
// Notes on behaviour
// - Proprietary signature sets limit: family A 500mA/1A/2A/2.4A, family B 2A, others 3A.
// - Configuration channel behaves as a Type-C sink, sequenced by a state machine.
// - In sink mode the input limit follows the advertised configuration-channel current.
// - On attach the machine picks the active configuration-channel line itself.
// - Advertised current is classed as 500mA, 1.5A or 3.0A and applied.
// - A changed advertised level updates the limit with no software action.
// - Source-role enable high removes Rd and connects the 180uA source.
// - Source-role enable high turns on reverse boost, 5.1V/1.5A out.
// - All USB pins unconnected means non-USB supply; limit is 3A.
// - Fast-charge resistor picks one of fifteen steps with a paired top-off.
// - Limit is 500mA before detection; SDP 500mA, CDP or DCP 1.5A.
// - Unknown adapter or contact-detect timeout sets the limit to 3A at most.
// - Input OK pulls low with valid switching input, or during reverse boost.
`timescale 1ns/1ps
module csd_detect #(
  parameter int unsigned ATTACH_CYCLES = csd_pkg::CC_ATTACH_CYCLES,
  parameter int unsigned LEVEL_CYCLES  = csd_pkg::CC_LEVEL_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        source_role_enable,
  input  wire logic [1:0]  cc1_level_in,
  input  wire logic [1:0]  cc2_level_in,
  input  wire logic        dpdn_done_in,
  input  wire logic [3:0]  dpdn_type_in,
  input  wire logic        vbus_valid_in,
  input  wire logic        buck_switching_in,
  input  wire logic [3:0]  fast_charge_set_pin,
  output logic      [11:0] input_limit_ma,
  output logic      [11:0] fast_charge_ma,
  output logic      [7:0]  topoff_current,
  output logic             attached,
  output logic             active_cc,
  output logic      [1:0]  cc_level,
  output logic             cc1_rd_en,
  output logic             cc2_rd_en,
  output logic             cc1_src_en,
  output logic             cc2_src_en,
  output logic             reverse_boost_en,
  output logic             input_ok_n_out,
  output logic             input_ok_n_oe
);

  logic [15:0] pin_s;
  logic        en_s;
  logic [1:0]  cc1_s;
  logic [1:0]  cc2_s;
  logic        dp_done_s;
  logic [3:0]  dp_type_s;
  logic        vbus_s;
  logic        buck_s;
  logic [3:0]  fc_code_s;

  csd_sync #(
    .WIDTH (16)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({source_role_enable, cc1_level_in, cc2_level_in, dpdn_done_in,
            dpdn_type_in, vbus_valid_in, buck_switching_in, fast_charge_set_pin}),
    .q    (pin_s)
  );

  assign {en_s, cc1_s, cc2_s, dp_done_s, dp_type_s, vbus_s, buck_s, fc_code_s} = pin_s;

  csd_fast_table u_fast (
    .clk       (clk),
    .nrst      (nrst),
    .code      (fc_code_s),
    .fast_ma   (fast_charge_ma),
    .topoff_ma (topoff_current)
  );

  csd_pkg::csd_state_t state_reg;
  csd_pkg::csd_state_t state_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic [3:0]  pat_reg;
  logic        active_cc_reg;
  logic [1:0]  cc_level_reg;
  logic [11:0] limit_reg;
  logic        ok_reg;

  // Pattern and level decode.
  wire       cc_any      = (cc1_s != csd_pkg::CC_OPEN) || (cc2_s != csd_pkg::CC_OPEN);
  wire       pat_same    = (pat_reg == {cc1_s, cc2_s});
  wire [1:0] act_lvl     = active_cc_reg ? cc2_s : cc1_s;
  wire       lvl_differs = (act_lvl != cc_level_reg);
  wire       attach_done = (cnt_reg >= ATTACH_CYCLES - 32'h1);
  wire       level_done  = (cnt_reg >= LEVEL_CYCLES - 32'h1);
  wire       pick_cc2    = (cc1_s == csd_pkg::CC_OPEN);
  wire       in_source   = (state_reg == csd_pkg::ST_SOURCE);
  wire       in_attached = (state_reg == csd_pkg::ST_ATTACHED);
  wire       lvl_commit  = in_attached && lvl_differs && pat_same && level_done;

  // Sink state machine; the source role overrides every sink state.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      csd_pkg::ST_UNATTACHED: begin
        if (cc_any) begin
          state_next = csd_pkg::ST_ATTACH_WAIT;
        end
      end
      csd_pkg::ST_ATTACH_WAIT: begin
        if (!cc_any) begin
          state_next = csd_pkg::ST_UNATTACHED;
        end else if (pat_same && attach_done) begin
          state_next = csd_pkg::ST_ATTACHED;
        end
      end
      csd_pkg::ST_ATTACHED: begin
        if (lvl_commit && act_lvl == csd_pkg::CC_OPEN) begin
          state_next = csd_pkg::ST_UNATTACHED;
        end
      end
      csd_pkg::ST_SOURCE: begin
        if (!en_s) begin
          state_next = csd_pkg::ST_UNATTACHED;
        end
      end
      default: state_next = csd_pkg::ST_UNATTACHED;
    endcase
    if (en_s) begin
      state_next = csd_pkg::ST_SOURCE;
    end
  end

  // One counter serves both debounces; it restarts whenever the wires move.
  always_comb begin
    cnt_next = cnt_reg + 32'h1;
    if (state_next != state_reg || !pat_same || (in_attached && !lvl_differs)) begin
      cnt_next = 32'h0;
    end else if (cnt_reg == 32'hffffffff) begin
      cnt_next = cnt_reg;
    end
  end

  // D+/D- result to limit; a code is trusted only while done is high.
  wire [11:0] dp_lim =
    !dp_done_s                      ? csd_pkg::LIM_500  :
    (dp_type_s == csd_pkg::DP_SDP)    ? csd_pkg::LIM_500  :
    (dp_type_s == csd_pkg::DP_CDP)    ? csd_pkg::LIM_1500 :
    (dp_type_s == csd_pkg::DP_DCP)    ? csd_pkg::LIM_1500 :
    (dp_type_s == csd_pkg::DP_PA_500) ? csd_pkg::LIM_500  :
    (dp_type_s == csd_pkg::DP_PA_1A)  ? csd_pkg::LIM_1000 :
    (dp_type_s == csd_pkg::DP_PA_2A)  ? csd_pkg::LIM_2000 :
    (dp_type_s == csd_pkg::DP_PA_2A4) ? csd_pkg::LIM_2400 :
    (dp_type_s == csd_pkg::DP_PB_2A)  ? csd_pkg::LIM_2000 :
    (dp_type_s == csd_pkg::DP_OPEN)   ? csd_pkg::LIM_500  :
                                        csd_pkg::LIM_3000;

  wire [11:0] cc_lim =
    (cc_level_reg == csd_pkg::CC_3A0) ? csd_pkg::LIM_3000 :
    (cc_level_reg == csd_pkg::CC_1A5) ? csd_pkg::LIM_1500 :
                                        csd_pkg::LIM_500;

  // With Type-C default current the D+/D- result may raise the limit.
  wire cc_high   = in_attached && (cc_level_reg == csd_pkg::CC_3A0 ||
                                   cc_level_reg == csd_pkg::CC_1A5);
  wire cc_dflt   = in_attached && !dp_done_s;
  wire non_usb   = !cc_any && dp_done_s && (dp_type_s == csd_pkg::DP_OPEN);
  wire [11:0] limit_next =
    in_source ? csd_pkg::LIM_500  :
    non_usb   ? csd_pkg::LIM_3000 :
    cc_high   ? cc_lim            :
    cc_dflt   ? cc_lim            :
                dp_lim;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= csd_pkg::ST_UNATTACHED;
      cnt_reg   <= 32'h0;
      pat_reg   <= 4'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      pat_reg   <= {cc1_s, cc2_s};
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      active_cc_reg <= 1'b0;
      cc_level_reg  <= csd_pkg::CC_OPEN;
    end else if (state_reg == csd_pkg::ST_ATTACH_WAIT &&
                 state_next == csd_pkg::ST_ATTACHED) begin
      active_cc_reg <= pick_cc2;
      cc_level_reg  <= pick_cc2 ? cc2_s : cc1_s;
    end else if (lvl_commit) begin
      cc_level_reg  <= act_lvl;
    end else if (state_reg != csd_pkg::ST_ATTACHED) begin
      cc_level_reg  <= csd_pkg::CC_OPEN;
    end
  end

  // Input OK is registered so it never glitches while the host watches it.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      limit_reg <= csd_pkg::LIM_500;
      ok_reg    <= 1'b0;
    end else begin
      limit_reg <= limit_next;
      ok_reg    <= (vbus_s && buck_s) || in_source;
    end
  end

  assign input_limit_ma   = limit_reg;
  assign attached         = in_attached;
  assign active_cc        = active_cc_reg;
  assign cc_level         = cc_level_reg;
  assign cc1_rd_en        = !in_source;
  assign cc2_rd_en        = !in_source;
  assign cc1_src_en       = in_source;
  assign cc2_src_en       = in_source;
  assign reverse_boost_en = in_source;
  assign input_ok_n_out   = 1'b0;
  assign input_ok_n_oe    = ok_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  state_onehot_a: assert property ($onehot(state_reg))
    else $error("State is not one-hot.");
  boost_on_a: assert property (en_s |=> reverse_boost_en)
    else $error("Boost not on after source-role enable.");
  // Checked from the synchronised enable, so a slip in the role decode shows up here.
  rd_swap_a: assert property (en_s |=> !cc1_rd_en && !cc2_rd_en &&
                              cc1_src_en && cc2_src_en)
    else $error("Rd still present in source role.");
  rd_restore_a: assert property (in_source && !en_s |=> cc1_rd_en && cc2_rd_en &&
                                 !reverse_boost_en && !cc1_src_en)
    else $error("Sink termination not restored.");
  ok_boost_a: assert property (in_source |=> input_ok_n_oe)
    else $error("Input OK not low during boost.");
  ok_input_a: assert property (!in_source && !(vbus_s && buck_s) |=> !input_ok_n_oe)
    else $error("Input OK low with no valid input.");
  pre_detect_a: assert property (!dp_done_s && !in_attached && !en_s && !in_source
                                 |=> input_limit_ma == csd_pkg::LIM_500)
    else $error("Limit not 500mA before detection.");
  sdp_lim_a: assert property (dp_done_s && dp_type_s == csd_pkg::DP_SDP
                              && !in_attached && !in_source
                              |=> input_limit_ma == csd_pkg::LIM_500)
    else $error("Standard port limit not 500mA.");
  charge_port_a: assert property (dp_done_s && !in_attached && !in_source &&
                                  (dp_type_s == csd_pkg::DP_CDP || dp_type_s == csd_pkg::DP_DCP)
                                  |=> input_limit_ma == csd_pkg::LIM_1500)
    else $error("Charging port limit not 1.5A.");
  non_usb_a: assert property (non_usb && !in_source |=>
                              input_limit_ma == csd_pkg::LIM_3000)
    else $error("Non-USB supply limit not 3A.");
  family_a_a: assert property (dp_done_s && dp_type_s == csd_pkg::DP_PA_2A4
                               && !in_attached && !in_source
                               |=> input_limit_ma == csd_pkg::LIM_2400)
    else $error("First family limit not 2.4A.");
  family_b_a: assert property (dp_done_s && dp_type_s == csd_pkg::DP_PB_2A
                               && !in_attached && !in_source
                               |=> input_limit_ma == csd_pkg::LIM_2000)
    else $error("Second family limit not 2A.");
  unknown_lim_a: assert property (dp_done_s && !in_attached &&
                                  (dp_type_s == csd_pkg::DP_UNKNOWN ||
                                   dp_type_s == csd_pkg::DP_DCD_TO)
                                  |=> input_limit_ma <= csd_pkg::LIM_3000)
    else $error("Unknown adapter limit above 3A.");
  cc_3a_a: assert property (in_attached && cc_level_reg == csd_pkg::CC_3A0 && !en_s
                            |=> input_limit_ma == csd_pkg::LIM_3000)
    else $error("Limit does not follow 3.0A advertisement.");
  cc_15_a: assert property (in_attached && cc_any && cc_level_reg == csd_pkg::CC_1A5
                            |=> input_limit_ma == csd_pkg::LIM_1500)
    else $error("Limit does not follow 1.5A advertisement.");
  level_upd_a: assert property (lvl_commit && act_lvl != csd_pkg::CC_OPEN && !en_s
                                |=> cc_level == $past(act_lvl))
    else $error("Advertised level change not applied.");
  // A level that moved without the full debounce would let a loose plug retune the limit.
  level_hold_a: assert property (in_attached && !lvl_commit |=>
                                 cc_level == $past(cc_level_reg))
    else $error("Advertised level moved without debounce.");
  attach_wait_a: assert property (state_reg == csd_pkg::ST_ATTACH_WAIT && !attach_done
                                  |=> !in_attached)
    else $error("Attach taken before debounce.");
  detach_wait_a: assert property (in_attached && act_lvl == csd_pkg::CC_OPEN &&
                                  !level_done && !en_s |=> in_attached)
    else $error("Detach taken before debounce.");
  pick_line_a: assert property (state_reg == csd_pkg::ST_ATTACH_WAIT &&
                                state_next == csd_pkg::ST_ATTACHED
                                |=> active_cc == $past(pick_cc2))
    else $error("Active line chosen wrongly.");
  fast_range_a: assert property ($past(nrst) |->
                                 fast_charge_ma >= csd_pkg::FAST_MIN &&
                                 fast_charge_ma <= csd_pkg::FAST_MAX &&
                                 topoff_current >= csd_pkg::TOP_MIN &&
                                 topoff_current <= csd_pkg::TOP_MAX)
    else $error("Fast-charge setting out of range.");
  source_lim_a: assert property (in_source |=> input_limit_ma == csd_pkg::LIM_500)
    else $error("Limit not idle in source role.");

  attach_c: cover property (state_reg == csd_pkg::ST_ATTACH_WAIT ##1 in_attached);
  level_c: cover property (lvl_commit && act_lvl != csd_pkg::CC_OPEN);
  source_c: cover property (in_source ##1 !in_source);
  prop_c: cover property (dp_done_s && dp_type_s == csd_pkg::DP_PA_2A4 && !cc_any);
  port_c: cover property (dp_done_s && dp_type_s == csd_pkg::DP_CDP && !cc_any);

endmodule : csd_detect

// ### sim/csd_adapter_model.sv
// Model of the attached adapter, plus a host that shares the D+/D- lines.
// Assumes the bench sets plug kind, orientation and codes just after a clock edge.
`timescale 1ns/1ps
module csd_adapter_model (
  input  wire logic       clk,
  input  wire logic       typec_on,
  input  wire logic       flip,
  input  wire logic [1:0] adv,
  input  wire logic       dp_go,
  input  wire logic [3:0] dp_code,
  input  wire logic       cc1_rd_en,
  input  wire logic       cc2_rd_en,
  input  wire logic       input_ok_n_oe,
  output logic      [1:0] cc1_lvl,
  output logic      [1:0] cc2_lvl,
  output logic            dp_done,
  output logic      [3:0] dp_type,
  output logic            vbus_ok,
  output logic            buck_on,
  output logic            host_on_dpdn
);
  logic [1:0] dp_cnt;
  initial begin
    dp_cnt = 2'h0;
    dp_done = 1'b0;
    dp_type = 4'h5;
    vbus_ok = 1'b0;
    buck_on = 1'b0;
    host_on_dpdn = 1'b0;
  end
  // A source advertises only towards a wire that shows Rd, so source role reads open.
  assign cc1_lvl = (typec_on && !flip && cc1_rd_en) ? adv : csd_pkg::CC_OPEN;
  assign cc2_lvl = (typec_on && flip && cc2_rd_en) ? adv : csd_pkg::CC_OPEN;
  always @(posedge clk) begin
    vbus_ok <= typec_on || dp_go;
    buck_on <= vbus_ok;
    if (dp_go) begin
      dp_type <= dp_code;
      if (dp_cnt != 2'h3) dp_cnt <= dp_cnt + 2'h1;
      dp_done <= (dp_cnt == 2'h3);
    end else begin
      // Released lines carry no result, so the code toggles instead of holding.
      dp_type <= ~dp_type;
      dp_cnt <= 2'h0;
      dp_done <= 1'b0;
    end
    host_on_dpdn <= input_ok_n_oe && dp_done;
  end
endmodule : csd_adapter_model

// ### sim/csd_detect_tb.sv
// Self-checking bench for the source detection and input limit block.
// Assumes shortened debounce counts and the adapter model on the far side.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  n_compared++; \
  if ((got) !== (ex)) begin \
    err_total++; \
    $display("mismatch %s expected %0h seen %0h", nm, ex, got); \
  end \
end
module csd_detect_tb;
  localparam int unsigned AT = 20;
  localparam int unsigned LV = 10;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        src_en = 1'b0;
  logic        typec_on = 1'b0;
  logic        flip = 1'b0;
  logic        dp_go = 1'b0;
  logic [1:0]  adv = 2'h0;
  logic [3:0]  dp_code = 4'h0;
  logic [3:0]  fset = 4'h0;
  logic [1:0]  cc1_l, cc2_l, lvl;
  logic [3:0]  dp_type;
  logic [11:0] lim, fast;
  logic [7:0]  top;
  logic        dp_done, vbus, buck, host_on, att, act, rd1, rd2, s1, s2, bst, okn, ok_oe;
  int          err_total = 0;
  int          n_compared = 0;
  always #2.5 clk = ~clk;
  csd_detect #(.ATTACH_CYCLES(AT), .LEVEL_CYCLES(LV)) u_csd_detect (
    .clk(clk), .nrst(nrst), .source_role_enable(src_en), .cc1_level_in(cc1_l),
    .cc2_level_in(cc2_l), .dpdn_done_in(dp_done), .dpdn_type_in(dp_type),
    .vbus_valid_in(vbus), .buck_switching_in(buck), .fast_charge_set_pin(fset),
    .input_limit_ma(lim), .fast_charge_ma(fast), .topoff_current(top), .attached(att),
    .active_cc(act), .cc_level(lvl), .cc1_rd_en(rd1), .cc2_rd_en(rd2), .cc1_src_en(s1),
    .cc2_src_en(s2), .reverse_boost_en(bst), .input_ok_n_out(okn), .input_ok_n_oe(ok_oe));
  csd_adapter_model u_csd_adapter_model (
    .clk(clk), .typec_on(typec_on), .flip(flip), .adv(adv), .dp_go(dp_go),
    .dp_code(dp_code), .cc1_rd_en(rd1), .cc2_rd_en(rd2), .input_ok_n_oe(ok_oe),
    .cc1_lvl(cc1_l), .cc2_lvl(cc2_l), .dp_done(dp_done), .dp_type(dp_type),
    .vbus_ok(vbus), .buck_on(buck), .host_on_dpdn(host_on));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic t_reset();
    cyc(2);
    @(posedge clk);
    nrst <= 1'b1;
    cyc(1);
    `CHK("limit", 12'h1f4, lim)
    `CHK("rd", 2'h3, {rd1, rd2})
    `CHK("boost", 1'h0, bst)
    `CHK("ok_oe", 1'h0, ok_oe)
    `CHK("ok_out", 1'h0, okn)
  endtask : t_reset
  task automatic t_fast();
    logic [11:0] f_exp [16] = '{12'h1f4, 12'h258, 12'h320, 12'h3e8, 12'h4b0, 12'h578,
      12'h5dc, 12'h708, 12'h7d0, 12'h898, 12'h960, 12'h9c4, 12'haf0, 12'hbb8, 12'hc4e,
      12'h1f4};
    logic [7:0] t_exp [16] = '{8'h32, 8'h32, 8'h32, 8'h32, 8'h32, 8'h4b, 8'h4b, 8'h4b,
      8'h64, 8'h64, 8'h7d, 8'h7d, 8'h7d, 8'h96, 8'h96, 8'h32};
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      fset <= 4'(i);
      cyc(6);
      `CHK("fast", f_exp[i], fast)
      `CHK("topoff", t_exp[i], top)
    end
  endtask : t_fast
  task automatic t_dpdn();
    logic [11:0] l_exp [12] = '{12'h1f4, 12'h5dc, 12'h5dc, 12'h1f4, 12'h3e8, 12'h7d0,
      12'h960, 12'h7d0, 12'hbb8, 12'hbb8, 12'hbb8, 12'hbb8};
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      dp_code <= 4'(i);
      dp_go <= 1'b1;
      cyc(10);
      `CHK("limit", l_exp[i], lim)
      `CHK("ok_oe", 1'h1, ok_oe)
      `CHK("host", 1'h1, host_on)
      @(posedge clk);
      dp_go <= 1'b0;
      cyc(8);
      `CHK("limit", 12'h1f4, lim)
      `CHK("ok_oe", 1'h0, ok_oe)
    end
  endtask : t_dpdn
  task automatic t_typec();
    for (int f = 0; f < 2; f++) begin
      @(posedge clk);
      typec_on <= 1'b1;
      flip <= f[0];
      adv <= f[0] ? csd_pkg::CC_1A5 : csd_pkg::CC_3A0;
      cyc(10);
      `CHK("attached", 1'h0, att)
      cyc(AT + 2);
      `CHK("attached", 1'h1, att)
      `CHK("active_cc", f[0], act)
      `CHK("limit", f[0] ? 12'h5dc : 12'hbb8, lim)
      @(posedge clk);
      adv <= f[0] ? csd_pkg::CC_3A0 : csd_pkg::CC_DEFAULT;
      cyc(LV + 8);
      `CHK("cc_level", adv, lvl)
      `CHK("limit", f[0] ? 12'hbb8 : 12'h1f4, lim)
      @(posedge clk);
      typec_on <= 1'b0;
      cyc(LV + 8);
      `CHK("attached", 1'h0, att)
    end
  endtask : t_typec
  task automatic t_source();
    @(posedge clk);
    typec_on <= 1'b1;
    adv <= csd_pkg::CC_1A5;
    cyc(AT + 12);
    @(posedge clk);
    src_en <= 1'b1;
    cyc(3);
    `CHK("boost", 1'h1, bst)
    `CHK("rd", 2'h0, {rd1, rd2})
    `CHK("src", 2'h3, {s1, s2})
    cyc(1);
    `CHK("ok_oe", 1'h1, ok_oe)
    `CHK("limit", 12'h1f4, lim)
    @(posedge clk);
    src_en <= 1'b0;
    typec_on <= 1'b0;
    cyc(4);
    `CHK("boost", 1'h0, bst)
    `CHK("src", 2'h0, {s1, s2})
    `CHK("rd", 2'h3, {rd1, rd2})
  endtask : t_source
  // A hang anywhere still reaches the closing report.
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    give_verdict();
  end
  initial begin
    t_reset();
    t_fast();
    t_dpdn();
    t_typec();
    t_source();
    give_verdict();
  end
endmodule : csd_detect_tb
